// file: common/acc_defs.svh
// Constants of the calibration correction datapath: codes, reset values, limits.
// Assumes inclusion by its bare name from the package and the core only.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Sizes of the coefficient and result stores
`define ACC_RESULT_SLOTS    8
`define ACC_GAIN_STEPS      8
// Coefficient reset values and gain limits (unsigned Q1.23)
`define ACC_OFFSET_RESET    24'h000000
`define ACC_GAIN_UNITY      24'h800000
`define ACC_GAIN_MAX        24'hFFFFFF
// Output saturation bounds, signed 24-bit range held in 32 bits
`define ACC_OUT_MAX         32'sh007FFFFF
`define ACC_OUT_MIN         32'shFF800000
`define ACC_OUT_POS_SAT     24'h7FFFFF
`define ACC_OUT_NEG_SAT     24'h800000
// Ideal full-scale reading in quarter-LSB units, shifted by the 23 gain fraction bits
`define ACC_FULL_SCALE_Q    48'hFFFFFE000000
`define ACC_DIV_STEPS       6'h30
// Calibration command codes
`define ACC_CMD_SELF        3'h0
`define ACC_CMD_PGA         3'h1
`define ACC_CMD_SYSTEM_OFFSET_COEFF_SET_A   3'h2
`define ACC_CMD_SYSTEM_GAIN_COEFF_SET_A  3'h3
`define ACC_CMD_SYSTEM_OFFSET_COEFF_SET_B   3'h4
`define ACC_CMD_SYSTEM_GAIN_COEFF_SET_B  3'h5
// System set selection codes; any other code bypasses the system set
`define ACC_SYS_SET_A       2'h1
`define ACC_SYS_SET_B       2'h2
// Direct coefficient load and readback selectors
`define ACC_SEL_SELF_OFF    4'h0
`define ACC_SEL_SELF_GAIN0  4'h1
`define ACC_SEL_SELF_GAIN7  4'h8
`define ACC_SEL_SYSTEM_OFFSET_COEFF_SET_A   4'h9
`define ACC_SEL_SYSTEM_GAIN_COEFF_SET_A  4'hA
`define ACC_SEL_SYSTEM_OFFSET_COEFF_SET_B   4'hB
`define ACC_SEL_SYSTEM_GAIN_COEFF_SET_B  4'hC

`endif

// file: common/acc_pkg.sv
// Types shared by the calibration correction datapath and its users.
// Assumes acc_defs.svh is on the include path.
`include "acc_defs.svh"

package acc_pkg;

    // Conversion settings that a calibration runs with
    typedef struct packed {
        logic [1:0] line_filter_select;  // Line rejection filter choice
        logic [3:0] rate;                // Conversion rate choice
        logic [2:0] gain;                // Amplifier gain 1x..128x as 0..7
    } acc_settings_t;

    // Direct coefficient load from host software
    typedef struct packed {
        logic        valid;  // One-cycle load strobe
        logic [3:0]  sel;    // Which coefficient
        logic [23:0] data;   // New coefficient value
    } acc_coeff_wr_t;

    // What the converter input is tied to for a calibration conversion
    typedef enum logic [1:0] {
        ACC_SRC_EXTERNAL,
        ACC_SRC_INT_ZERO,
        ACC_SRC_INT_FULL
    } acc_source_t;

    // Calibration sequencer states
    typedef enum logic [2:0] {
        ACC_CAL_IDLE,
        ACC_CAL_REQUEST,
        ACC_CAL_WAIT,
        ACC_CAL_DIVIDE,
        ACC_CAL_STORE
    } acc_cal_state_t;

endpackage

// file: verilog/acc_core.sv
// Calibration correction datapath: coefficient store, correction arithmetic,
// result slots and the calibration sequencer with its gain divider.
// Assumes raw conversions arrive on this clock from the converter back end.
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_core #(
    parameter int RESULT_SLOTS = `ACC_RESULT_SLOTS
) (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          raw_valid,
    input  wire logic [23:0]                   raw_data,
    input  wire acc_pkg::acc_settings_t        settings,
    input  wire logic [1:0]                    system_set_select,
    input  wire logic [3:0]                    result_slot_select,
    input  wire logic                          cal_cmd_valid,
    input  wire logic [2:0]                    cal_cmd_type,
    input  wire acc_pkg::acc_coeff_wr_t        coeff_wr,
    input  wire logic [3:0]                    coeff_rd_sel,
    output logic [23:0]                        coeff_rd_data,
    output logic [RESULT_SLOTS-1:0][23:0]      result_bank,
    output logic                               result_valid,
    output logic                               cal_busy,
    output logic                               cal_conv_start,
    output acc_pkg::acc_source_t               cal_source,
    output acc_pkg::acc_settings_t             cal_settings
);
    import acc_pkg::*;

    // Slot field is four bits wide, so more than sixteen slots are unreachable
    if (RESULT_SLOTS < 1 || RESULT_SLOTS > 16) begin : g_slot_check
        $error("RESULT_SLOTS must lie between 1 and 16");
    end

    // Sign-extend a 24-bit coefficient to the working width
    function automatic logic signed [31:0] sext24(input logic [23:0] c);
        sext24 = {{8{c[23]}}, c};
    endfunction

    // Multiply by an unsigned Q1.23 gain; 57-bit product cannot overflow
    function automatic logic signed [31:0] mul_q23(input logic signed [31:0] a, input logic [23:0] g);
        logic signed [56:0] p;
        p = a * $signed({1'b0, g});
        mul_q23 = p[54:23];
    endfunction

    // Clamp to the signed 24-bit range instead of wrapping
    function automatic logic [23:0] sat24(input logic signed [31:0] v);
        if (v > `ACC_OUT_MAX) begin
            sat24 = `ACC_OUT_POS_SAT;
        end else if (v < `ACC_OUT_MIN) begin
            sat24 = `ACC_OUT_NEG_SAT;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    // Coefficient store
    logic [23:0]    self_off_r;                           // Internal offset, two's complement
    logic [23:0]    self_gain_r [`ACC_GAIN_STEPS];        // Internal gain per amplifier gain
    logic [23:0]    sys_off_r   [2];                      // System offsets, set A then B
    logic [23:0]    sys_gain_r  [2];                      // System gains, set A then B
    // Sequencer state
    acc_cal_state_t state_r;                              // Calibration sequencer state
    acc_cal_state_t state_nxt;                            // Its next value
    logic [2:0]     cal_type_r;                           // Calibration in progress
    logic           phase_r;                              // Second self-calibration conversion
    acc_settings_t  cal_settings_r;                       // Settings captured at the command
    acc_source_t    cal_source_r;                         // Input tie-off for the conversion
    acc_source_t    source_nxt;                           // Its next value
    // Gain divider
    logic [47:0]    div_num_r;                            // Dividend, shifted out MSB first
    logic [31:0]    div_den_r;                            // Measured span, positive
    logic [31:0]    div_rem_r;                            // Partial remainder
    logic [47:0]    div_quo_r;                            // Quotient, shifted in at the LSB, MSB first
    logic [5:0]     div_cnt_r;                            // Steps left
    // Result side
    logic           result_valid_r;                       // Result written this cycle
    logic [23:0]    coeff_rd_r;                           // Readback register
    logic [RESULT_SLOTS-1:0][23:0] result_bank_r;         // Result slots
    logic [23:0]    coeff_view;                           // Readback selection

    // Correction chain: everything is held in quarter-LSB units, so a full
    // offset code of 0x7FFFFF is a quarter of the reference swing
    wire logic signed [31:0] raw_ext       = sext24(raw_data);
    wire logic signed [31:0] raw_quarter   = raw_ext <<< 2;
    wire logic signed [31:0] stage_x       = raw_quarter - sext24(self_off_r);
    wire logic [23:0]        sel_self_gain = self_gain_r[settings.gain];
    wire logic signed [31:0] stage_y       = mul_q23(stage_x, sel_self_gain);
    wire logic               use_set_a     = system_set_select == `ACC_SYS_SET_A;
    wire logic               use_set_b     = system_set_select == `ACC_SYS_SET_B;
    wire logic               use_sys       = use_set_a | use_set_b;
    wire logic [23:0]        sel_sys_off   = use_set_b ? sys_off_r[1] : sys_off_r[0];
    wire logic [23:0]        sel_sys_gain  = use_set_b ? sys_gain_r[1] : sys_gain_r[0];
    wire logic signed [31:0] stage_z       = stage_y - sext24(sel_sys_off);
    wire logic signed [31:0] stage_w       = use_sys ? mul_q23(stage_z, sel_sys_gain) : stage_y;
    wire logic signed [31:0] stage_out     = stage_w >>> 2;
    wire logic [23:0]        corrected     = sat24(stage_out);

    // Result routing; slot codes beyond the store are dropped
    wire logic slot_ok    = int'(result_slot_select) < RESULT_SLOTS;
    wire logic normal_cnv = raw_valid && (state_r == ACC_CAL_IDLE);
    wire logic do_result  = normal_cnv && slot_ok;

    // Command acceptance; anything arriving while busy is ignored
    wire logic cmd_take   = cal_cmd_valid && (state_r == ACC_CAL_IDLE) && (cal_cmd_type <= `ACC_CMD_SYSTEM_GAIN_COEFF_SET_B);
    wire logic is_self    = cal_type_r == `ACC_CMD_SELF;
    wire logic is_pga     = cal_type_r == `ACC_CMD_PGA;
    wire logic is_sys_off = (cal_type_r == `ACC_CMD_SYSTEM_OFFSET_COEFF_SET_A) || (cal_type_r == `ACC_CMD_SYSTEM_OFFSET_COEFF_SET_B);
    wire logic is_set_b   = (cal_type_r == `ACC_CMD_SYSTEM_OFFSET_COEFF_SET_B) || (cal_type_r == `ACC_CMD_SYSTEM_GAIN_COEFF_SET_B);
    wire logic cal_meas   = (state_r == ACC_CAL_WAIT) && raw_valid;

    // Measurements taken by calibration, corrected up to the stage in front
    // of the coefficient being calculated
    wire logic [23:0]        cal_sys_off    = is_set_b ? sys_off_r[1] : sys_off_r[0];
    wire logic signed [31:0] meas_span      = (is_self || is_pga) ? stage_x : (stage_y - sext24(cal_sys_off));
    wire logic               span_bad       = meas_span <= 32'sh00000000;
    wire logic               store_self_off = cal_meas && is_self && !phase_r;
    wire logic               store_sys_off  = cal_meas && is_sys_off;
    wire logic               store_gain     = state_r == ACC_CAL_STORE;
    wire logic [23:0]        self_off_new   = sat24(raw_quarter);
    wire logic [23:0]        sys_off_new    = sat24(stage_y);
    wire logic [23:0]        gain_new       = (|div_quo_r[47:24]) ? `ACC_GAIN_MAX : div_quo_r[23:0];
    wire logic [2:0]         pga_slot       = is_self ? 3'h0 : cal_settings_r.gain;

    // Restoring divider step: ideal full scale over measured span
    wire logic [32:0] rem_shift = {div_rem_r, div_num_r[47]};
    wire logic        rem_ge    = rem_shift >= {1'b0, div_den_r};
    wire logic [32:0] rem_diff  = rem_shift - {1'b0, div_den_r};
    wire logic [31:0] rem_next  = rem_ge ? rem_diff[31:0] : rem_shift[31:0];

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACC_CAL_IDLE:    if (cmd_take) state_nxt = ACC_CAL_REQUEST;
            ACC_CAL_REQUEST: state_nxt = ACC_CAL_WAIT;
            ACC_CAL_WAIT: begin
                if (store_self_off) begin
                    state_nxt = ACC_CAL_REQUEST;
                end else if (store_sys_off) begin
                    state_nxt = ACC_CAL_IDLE;
                end else if (cal_meas) begin
                    state_nxt = span_bad ? ACC_CAL_STORE : ACC_CAL_DIVIDE;
                end
            end
            ACC_CAL_DIVIDE:  if (div_cnt_r == 6'h01) state_nxt = ACC_CAL_STORE;
            ACC_CAL_STORE:   state_nxt = ACC_CAL_IDLE;
            default:         state_nxt = ACC_CAL_IDLE;
        endcase
    end

    // Input tie-off for the next calibration conversion
    always_comb begin
        source_nxt = cal_source_r;
        case (state_nxt)
            ACC_CAL_REQUEST: begin
                if (cmd_take) begin
                    source_nxt = (cal_cmd_type == `ACC_CMD_SELF) ? ACC_SRC_INT_ZERO :
                                 (cal_cmd_type == `ACC_CMD_PGA)  ? ACC_SRC_INT_FULL : ACC_SRC_EXTERNAL;
                end else begin
                    source_nxt = ACC_SRC_INT_FULL;
                end
            end
            ACC_CAL_IDLE:    source_nxt = ACC_SRC_EXTERNAL;
            default:         source_nxt = cal_source_r;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r        <= ACC_CAL_IDLE;
            cal_type_r     <= `ACC_CMD_SELF;
            phase_r        <= 1'b0;
            cal_settings_r <= '0;
            cal_source_r   <= ACC_SRC_EXTERNAL;
        end else begin
            state_r      <= state_nxt;
            cal_source_r <= source_nxt;
            if (cmd_take) begin
                cal_type_r     <= cal_cmd_type;
                cal_settings_r <= settings;
                phase_r        <= 1'b0;
            end else if (store_self_off) begin
                phase_r <= 1'b1;
            end
        end
    end

    // Gain divider; a non-positive span gives the largest gain at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_num_r <= '0;
            div_den_r <= '0;
            div_rem_r <= '0;
            div_quo_r <= '0;
            div_cnt_r <= '0;
        end else if (cal_meas && !store_self_off && !store_sys_off) begin
            div_num_r <= `ACC_FULL_SCALE_Q;
            div_den_r <= meas_span;
            div_rem_r <= '0;
            div_quo_r <= span_bad ? {48{1'b1}} : 48'h000000000000;
            div_cnt_r <= `ACC_DIV_STEPS;
        end else if (state_r == ACC_CAL_DIVIDE) begin
            div_num_r <= {div_num_r[46:0], 1'b0};
            div_rem_r <= rem_next;
            div_quo_r <= {div_quo_r[46:0], rem_ge};
            div_cnt_r <= div_cnt_r - 6'h01;
        end
    end

    // Coefficient store: a host load lands first, a calibration result to
    // the same coefficient in the same cycle overrides it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            self_off_r <= `ACC_OFFSET_RESET;
            for (int i = 0; i < `ACC_GAIN_STEPS; i++) begin
                self_gain_r[i] <= `ACC_GAIN_UNITY;
            end
            for (int i = 0; i < 2; i++) begin
                sys_off_r[i]  <= `ACC_OFFSET_RESET;
                sys_gain_r[i] <= `ACC_GAIN_UNITY;
            end
        end else begin
            if (coeff_wr.valid) begin
                case (coeff_wr.sel)
                    `ACC_SEL_SELF_OFF:   self_off_r    <= coeff_wr.data;
                    `ACC_SEL_SYSTEM_OFFSET_COEFF_SET_A:  sys_off_r[0]  <= coeff_wr.data;
                    `ACC_SEL_SYSTEM_GAIN_COEFF_SET_A: sys_gain_r[0] <= coeff_wr.data;
                    `ACC_SEL_SYSTEM_OFFSET_COEFF_SET_B:  sys_off_r[1]  <= coeff_wr.data;
                    `ACC_SEL_SYSTEM_GAIN_COEFF_SET_B: sys_gain_r[1] <= coeff_wr.data;
                    default: begin
                        if (coeff_wr.sel >= `ACC_SEL_SELF_GAIN0 && coeff_wr.sel <= `ACC_SEL_SELF_GAIN7) begin
                            self_gain_r[3'(coeff_wr.sel - `ACC_SEL_SELF_GAIN0)] <= coeff_wr.data;
                        end
                    end
                endcase
            end
            if (store_self_off) begin
                self_off_r <= self_off_new;
            end
            if (store_sys_off) begin
                sys_off_r[is_set_b] <= sys_off_new;
            end
            if (store_gain && (is_self || is_pga)) begin
                self_gain_r[pga_slot] <= gain_new;
            end
            if (store_gain && !is_self && !is_pga) begin
                sys_gain_r[is_set_b] <= gain_new;
            end
        end
    end

    // Readback selection
    always_comb begin
        coeff_view = 24'h000000;
        case (coeff_rd_sel)
            `ACC_SEL_SELF_OFF:   coeff_view = self_off_r;
            `ACC_SEL_SYSTEM_OFFSET_COEFF_SET_A:  coeff_view = sys_off_r[0];
            `ACC_SEL_SYSTEM_GAIN_COEFF_SET_A: coeff_view = sys_gain_r[0];
            `ACC_SEL_SYSTEM_OFFSET_COEFF_SET_B:  coeff_view = sys_off_r[1];
            `ACC_SEL_SYSTEM_GAIN_COEFF_SET_B: coeff_view = sys_gain_r[1];
            default: begin
                if (coeff_rd_sel >= `ACC_SEL_SELF_GAIN0 && coeff_rd_sel <= `ACC_SEL_SELF_GAIN7) begin
                    coeff_view = self_gain_r[3'(coeff_rd_sel - `ACC_SEL_SELF_GAIN0)];
                end
            end
        endcase
    end

    // Result slots and readback; calibration conversions never reach a slot
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_bank_r  <= '0;
            result_valid_r <= 1'b0;
            coeff_rd_r     <= 24'h000000;
        end else begin
            result_valid_r <= do_result;
            coeff_rd_r     <= coeff_view;
            if (do_result) begin
                result_bank_r[result_slot_select] <= corrected;
            end
        end
    end

    assign result_bank    = result_bank_r;
    assign result_valid   = result_valid_r;
    assign coeff_rd_data  = coeff_rd_r;
    assign cal_busy       = state_r != ACC_CAL_IDLE;
    assign cal_conv_start = state_r == ACC_CAL_REQUEST;
    assign cal_source     = cal_source_r;
    assign cal_settings   = cal_settings_r;

    // Helper: first edge after reset release, and conversions per calibration
    logic       first_edge_r;
    logic [1:0] conv_cnt_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_edge_r <= 1'b1;
            conv_cnt_r   <= 2'h0;
        end else begin
            first_edge_r <= 1'b0;
            conv_cnt_r   <= cmd_take ? 2'h0 : conv_cnt_r + {1'b0, cal_conv_start};
        end
    end

    reset_values_a: assert property (@(posedge clock) disable iff (!rst_n)
        first_edge_r |-> (self_off_r == 24'h000000) && (self_gain_r[7] == 24'h800000)
                         && (sys_gain_r[1] == 24'h800000) && (sys_off_r[0] == 24'h000000))
        else $error("coefficients not at reset values");
    cmd_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_take |=> cal_busy && cal_conv_start && (cal_type_r == $past(cal_cmd_type)))
        else $error("calibration command did not start");
    direct_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        (coeff_wr.valid && coeff_wr.sel == 4'hA && !store_gain) |=> sys_gain_r[0] == $past(coeff_wr.data))
        else $error("direct coefficient load lost");
    unity_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
        (do_result && sel_self_gain == 24'h800000 && self_off_r == 24'h000000 && !use_sys)
        |=> result_bank_r[$past(result_slot_select)] == $past(raw_data))
        else $error("neutral coefficients altered the conversion");
    slot_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        do_result |=> result_valid && result_bank_r[$past(result_slot_select)] == $past(corrected))
        else $error("result not in the selected slot");
    cal_settings_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_take |=> cal_settings == $past(settings))
        else $error("calibration settings not captured");
    bypass_a: assert property (@(posedge clock) disable iff (!rst_n)
        (do_result && !use_sys) |=> result_bank_r[$past(result_slot_select)] == sat24($past(stage_y) >>> 2))
        else $error("system set applied while bypassed");
    self_source_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_take && cal_cmd_type == 3'h0) |=> cal_source == ACC_SRC_INT_ZERO)
        else $error("self calibration not on internal zero");
    self_two_a: assert property (@(posedge clock) disable iff (!rst_n)
        (store_gain && is_self) |-> conv_cnt_r == 2'h2)
        else $error("self calibration did not use two conversions");
    pga_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        (store_gain && is_pga) |=> conv_cnt_r == 2'h1 && self_gain_r[$past(cal_settings_r.gain)] == $past(gain_new))
        else $error("gain calibration wrong count or slot");
    saturate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (stage_out > 32'sh007FFFFF) |-> corrected == 24'h7FFFFF)
        else $error("result wrapped instead of saturating");

endmodule

// file: sim/acc_core_tb_top.sv
// Bench for the calibration correction datapath: reset values, loads, conversions and calibrations.
// Assumes acc_pkg is compiled first; all inputs change on the falling clock edge.
`timescale 1ns/1ps
module acc_core_tb_top;
    import acc_pkg::*;
    logic             clock, rst_n, raw_valid, cal_cmd_valid, res_v, busy, conv_start; // Strobes and status
    logic [23:0]      raw_data, coeff_rd_data;  // Raw sample and readback
    acc_settings_t    settings, cal_settings;   // Live and captured settings
    logic [1:0]       sys_sel;                  // System set choice
    logic [3:0]       slot, rd_sel;             // Result slot, readback selector
    logic [2:0]       cmd;                      // Command type
    acc_coeff_wr_t    coeff_wr;                 // Direct load
    logic [7:0][23:0] bank;                     // Result slots
    acc_source_t      source;                   // Calibration input source
    int               n_errors = 0, checks_done = 0, i;
    acc_core uut (.clock, .rst_n, .raw_valid, .raw_data, .settings, .system_set_select(sys_sel),
        .result_slot_select(slot), .cal_cmd_valid, .cal_cmd_type(cmd), .coeff_wr, .coeff_rd_sel(rd_sel),
        .coeff_rd_data, .result_bank(bank), .result_valid(res_v), .cal_busy(busy),
        .cal_conv_start(conv_start), .cal_source(source), .cal_settings);
    // Free-running 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Readback is registered, so the value shows one edge after selecting
    task rd(input logic [3:0] s);
        rd_sel = s;
        @(negedge clock);
    endtask
    // Extra idle cycle keeps the strobe from being raised twice in one step
    task ld(input logic [3:0] s, input logic [23:0] d);
        coeff_wr = '{1'b1, s, d};
        @(negedge clock) coeff_wr.valid = 1'b0;
        @(negedge clock);
    endtask
    task conv(input logic [23:0] r, input logic [3:0] s, input logic v, input logic [23:0] e);
        raw_data = r;
        slot = s;
        raw_valid = 1'b1;
        @(negedge clock) raw_valid = 1'b0;
        chk(24'(res_v), 24'(v));
        if (v) chk(bank[s], e);
        @(negedge clock);
    endtask
    // Waits for a measurement request, then answers one cycle later
    task cal_raw(input logic [23:0] r, input acc_source_t src);
        for (i = 0; i < 60 && conv_start !== 1'b1; i++) @(negedge clock);
        chk(24'(conv_start), 24'h1);
        chk(24'(source), 24'(src));
        @(negedge clock) raw_data = r;
        raw_valid = 1'b1;
        @(negedge clock) raw_valid = 1'b0;
    endtask
    task cal_cmd(input logic [2:0] c);
        cmd = c;
        cal_cmd_valid = 1'b1;
        @(negedge clock) cal_cmd_valid = 1'b0;
        chk(24'(busy), 24'(c < 3'h6));
    endtask
    // Bounded wait for the sequencer to fall idle; a hang counts as a mismatch
    task wait_idle;
        for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clock);
        chk(24'(busy), 24'h0);
    endtask
    task t_reset;
        for (int s = 0; s < 14; s++) begin
            rd(4'(s));
            chk(coeff_rd_data, (s inside {[1:8], 10, 12}) ? 24'h800000 : 24'h000000);
        end
        $display("test reset done");
    endtask
    task t_conv;
        conv(24'h000100, 4'h3, 1'b1, 24'h000100);
        ld(4'h0, 24'h000040);
        ld(4'h2, 24'h400000);
        settings.gain = 3'h1;
        conv(24'h000100, 4'h7, 1'b1, 24'h000078);
        conv(24'h000100, 4'h8, 1'b0, 24'h0);
        ld(4'h9, 24'h000020);
        ld(4'hB, 24'h000080);
        ld(4'hC, 24'h400000);
        ld(4'hA, 24'h600000);
        sys_sel = 2'h1;
        conv(24'h000100, 4'h1, 1'b1, 24'h000054);
        sys_sel = 2'h2;
        conv(24'h000100, 4'h2, 1'b1, 24'h00002C);
        sys_sel = 2'h3;
        conv(24'h000100, 4'h4, 1'b1, 24'h000078);
        settings.gain = 3'h0;
        ld(4'h1, 24'hFFFFFF);
        conv(24'h7FFFFF, 4'h5, 1'b1, 24'h7FFFFF);
        conv(24'h800000, 4'h6, 1'b1, 24'h800000);
        $display("test conversion done");
    endtask
    task t_cal;
        ld(4'h1, 24'h800000);
        ld(4'h4, 24'h456789);
        cal_cmd(3'h0);
        chk(24'(cal_settings), 24'(settings));
        cal_raw(24'h000020, ACC_SRC_INT_ZERO);
        cal_raw(24'h3FFFFF, ACC_SRC_INT_FULL);
        wait_idle;
        rd(4'h0);
        chk(coeff_rd_data, 24'h000080);
        rd(4'h1);
        chk(coeff_rd_data, 24'hFFFFFF);
        ld(4'h0, 24'h000000);
        settings.gain = 3'h3;
        cal_cmd(3'h1);
        cal_raw(24'h7FFFFF, ACC_SRC_INT_FULL);
        wait_idle;
        rd(4'h4);
        chk(coeff_rd_data, 24'h800000);
        rd(4'h1);
        chk(coeff_rd_data, 24'hFFFFFF);
        // System offset A from an external zero, then system gain B over the set B offset
        cal_cmd(3'h2);
        cal_raw(24'h000030, ACC_SRC_EXTERNAL);
        wait_idle;
        rd(4'h9);
        chk(coeff_rd_data, 24'h0000C0);
        cal_cmd(3'h5);
        cal_raw(24'h7FFFFF, ACC_SRC_EXTERNAL);
        wait_idle;
        rd(4'hC);
        chk(coeff_rd_data, 24'h800020);
        cal_cmd(3'h6);
        $display("test calibration done");
    endtask
    // Reset for 12 cycles, then the scenarios in order
    initial begin
        {rst_n, raw_valid, cal_cmd_valid, raw_data, sys_sel, slot, rd_sel, cmd} = '0;
        coeff_wr = '0;
        settings = '{2'h2, 4'h5, 3'h0};
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        t_reset;
        t_conv;
        t_cal;
        tally_and_finish;
    end
    // Whole run needs a few hundred cycles
    initial begin
        #50us n_errors++;
        tally_and_finish;
    end
endmodule
